// ==== src/pibt_consts.vh ====
// Constants for the inbound base address translation bridge.
`ifndef PIBT_CONSTS_VH
`define PIBT_CONSTS_VH
`define PIBT_OFF_MAPW 8'h10
`define PIBT_OFF_SPARE 8'h14
`define PIBT_OFF_MB0W 8'h18
`define PIBT_OFF_MB1W 8'h1c
`define PIBT_OFF_LOWW 8'h20
`define PIBT_OFF_HIGHW 8'h24
`define PIBT_OFF_ROM 8'h30
`define PIBT_OFF_EN 8'h40
`define PIBT_OFF_MAP0 8'h44
`define PIBT_OFF_MAPN 8'h80
`define PIBT_MAP0_IDX 6'h11
`define PIBT_RST_MAPW 32'h60000000
`define PIBT_RST_MB0W 32'h70000000
`define PIBT_RST_MB1W 32'h71000000
`define PIBT_RST_LOWW 32'h00000000
`define PIBT_RST_HIGHW 32'h80000000
`define PIBT_RST_ROM 32'h73000000
`define PIBT_RST_EN 2'h3
`define PIBT_PREF 32'h00000004
`define PIBT_MSK_MAPW 32'hff000000
`define PIBT_MSK_MBOX 32'hfffff000
`define PIBT_MSK_LOWW 32'hc0000000
`define PIBT_MSK_HIGHW 32'h80000000
`define PIBT_MSK_ROM 32'hffff0000
`define PIBT_ROM_EN 32'h00000001
`define PIBT_MAP_EN 0
`define PIBT_MAP_LINK 1
`define PIBT_MAP_ENDIAN 2
`define PIBT_MAP_L2CA 3
`define PIBT_MBOX0 40'h0010021000
`define PIBT_MBOX1 40'h0010023000
`define PIBT_ROMBASE 40'h001fd00000
`define PIBT_IO_LOW 3'h2
`define PIBT_MRD 4'h6
`define PIBT_MWR 4'h7
`define PIBT_CRD 4'ha
`define PIBT_CWR 4'hb
`define PIBT_MRM 4'hc
`define PIBT_MRL 4'he
`define PIBT_MWI 4'hf
`define PIBT_IB_CRD 3'h0
`define PIBT_IB_URD 3'h1
`define PIBT_IB_WINV 3'h2
`define PIBT_IB_RDX 3'h3
`define PIBT_IB_WB 3'h4
`define PIBT_IB_UWR 3'h5
`define PIBT_IB_MBOX 3'h6
`define PIBT_ALL_BE 32'hffffffff
`endif

// ==== src/pibt_bridge.v ====
// Inbound PCI target: window decode, address translation and internal issue.
// Summary of operation
// R1: Type 0 header, six base slots; five used as host, three as device.
// R2: First window: a[23:20] picks map entry giving [39:20]; [19:0] pass.
// R3: Enabled entry claims the cycle; disabled entry leaves it unclaimed.
// R4: Entry bit routes to the chained link or internally, overriding address.
// R5: Internal entries also give endian policy and allocate-on-miss flag.
// R6: Map table at h44..h80, writable only from the system side.
// R7: Memory base registers read back with prefetchable bit 2 set.
// R8: Host mode bases are read-only defaults, enabled from reset.
// R9: Mailbox windows: reads return value, writes only set bits.
// R10: Low-memory window, host only, enable in h40, a[29] selects endian.
// R11: High-memory window, host only, two 512 MB sections, a[29] endian.
// R12: Boot ROM window maps 64 KB, decoded only while bit 0 set.
// R13: Reads fetch a whole line; coherent for memory, uncached otherwise.
// R14: Masters reading registers must use line-aligned addresses.
// R15: Writes gathered; full line write-invalidate, partial read-excl merge.
// R16: Non-memory writes go uncached with exactly the written byte enables.
// R17: While holding a merge line, answer as owner and supply the data.
// R18: Claimed cycles complete or target-abort; bus errors target-abort.
// R19: A read whose forwarded request errors is target-aborted.
// R20: Link-bound request target-aborted while peer-to-peer is disabled.
// R21: Internal request mapped into outbound bridge space target-aborted.
`include "pibt_consts.vh"
`default_nettype none
module pibt_bridge (
  input wire clock,
  input wire rst_n,
  input wire host_strap,
  input wire ptp_en,
  input wire pci_clk,
  input wire pci_frame_n,
  input wire pci_irdy_n,
  input wire pci_idsel,
  input wire pci_par,
  input wire [3:0] pci_cbe_n,
  input wire [31:0] pci_ad_in,
  output reg [31:0] pci_ad_out,
  output reg pci_ad_oe_n,
  output reg target_claim_n,
  output reg pci_trdy_n,
  output reg pci_stop_n,
  output reg pci_ctl_oe_n,
  output reg ib_req,
  output reg [2:0] ib_cmd,
  output reg [39:0] ib_addr,
  output reg [31:0] ib_be,
  output wire [255:0] ib_wdata,
  output reg ib_to_link,
  output reg ib_endian,
  output reg l2_allocate_on_miss_flag,
  input wire ib_done,
  input wire ib_err,
  input wire [255:0] ib_rdata,
  input wire snoop_valid,
  input wire [34:0] snoop_line,
  output reg snoop_owner,
  output wire [255:0] snoop_data,
  input wire sys_cfg_wr,
  input wire [7:0] sys_cfg_addr,
  input wire [31:0] sys_cfg_wdata,
  output reg [31:0] sys_cfg_rdata,
  output reg host_mode
);
  localparam S_IDLE = 3'd0;
  localparam S_WGATH = 3'd1;
  localparam S_ISSUE = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_MERGE = 3'd4;
  localparam S_RDATA = 3'd5;
  localparam S_ABORT = 3'd6;
  localparam S_DONE = 3'd7;

  reg [40:0] s1;
  reg [40:0] s2;
  reg pclk_d;
  reg [2:0] state;
  reg [2:0] widx;
  reg wr_q;
  reg cfg_q;
  reg mem_q;
  reg mbox_q;
  reg rdx_q;
  reg strap_done;
  reg [7:0] cfg_off;
  reg [255:0] line_data;
  reg [31:0] line_be;
  reg [31:0] map_base;
  reg [31:0] mb0_base;
  reg [31:0] mb1_base;
  reg [31:0] low_base;
  reg [31:0] high_base;
  reg [31:0] rom;
  reg [1:0] en_reg;
  reg [31:0] map_tab [0:15];
  reg [39:0] xa;
  reg to_link;
  reg endn;
  reg l2ca;
  reg mbox;
  wire [255:0] merged;
  integer i;

  // PCI pins are sampled by the core clock; edges of pci_clk are found here.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 41'h0c000000000;
      s2 <= 41'h0c000000000;
      pclk_d <= 1'b0;
    end else begin
      s1 <= {pci_clk, pci_frame_n, pci_irdy_n, pci_idsel, pci_par,
             pci_cbe_n, pci_ad_in};
      s2 <= s1;
      pclk_d <= s2[40];
    end
  end

  wire pedge = s2[40] & ~pclk_d;
  wire fr = ~s2[39];
  wire ir = ~s2[38];
  wire [3:0] cmd = s2[35:32];
  wire [31:0] ad = s2[31:0];
  wire perr = (^{ad, cmd}) != s2[36];
  wire is_mem = (cmd == `PIBT_MRD) | (cmd == `PIBT_MWR) |
                (cmd == `PIBT_MRM) | (cmd == `PIBT_MRL) | (cmd == `PIBT_MWI);
  wire is_cfg = s2[37] & ((cmd == `PIBT_CRD) | (cmd == `PIBT_CWR)) &
                (ad[1:0] == 2'b00);
  wire [31:0] me = map_tab[ad[23:20]];
  wire h0 = (ad & `PIBT_MSK_MAPW) == map_base;
  wire h2 = (ad & `PIBT_MSK_MBOX) == mb0_base;
  wire h3 = (ad & `PIBT_MSK_MBOX) == mb1_base;
  wire hr = rom[0] & ((ad & `PIBT_MSK_ROM) == (rom & `PIBT_MSK_ROM));
  wire h4 = host_mode & en_reg[0] & ((ad & `PIBT_MSK_LOWW) == low_base);
  wire h5 = host_mode & en_reg[1] & ((ad & `PIBT_MSK_HIGHW) == high_base);
  // A hit in the first window with a disabled entry is never claimed.
  wire hit = h0 ? me[`PIBT_MAP_EN] : (h2 | h3 | hr | h4 | h5); // R3 R12
  wire xa_io = xa[39] | ((xa[39:32] == 8'h00) & (xa[31:29] == `PIBT_IO_LOW));
  wire xa_mem = ~xa[39] & ((xa[39:32] != 8'h00) | (xa[31:28] == 4'h0) |
                xa[31]);
  wire abort_a = perr | ~is_mem | (to_link & ~ptp_en) | // R18 R20
                 (~to_link & xa_io); // R21
  wire pwe = (state == S_WGATH) & cfg_q & pedge & ir & ~perr;
  wire [5:0] smi = sys_cfg_addr[7:2] - `PIBT_MAP0_IDX;
  wire sys_map = (sys_cfg_addr >= `PIBT_OFF_MAP0) &
                 (sys_cfg_addr <= `PIBT_OFF_MAPN) & (sys_cfg_addr[1:0] == 2'b00);

  assign ib_wdata = line_data;
  assign snoop_data = line_data;

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : merge_byte
      assign merged[8*g+7:8*g] = line_be[g] ? line_data[8*g+7:8*g] :
                                 ib_rdata[8*g+7:8*g]; // R15
    end
  endgenerate

  always @* begin
    xa = 40'h0;
    to_link = 1'b0;
    endn = 1'b0;
    l2ca = 1'b0;
    mbox = 1'b0;
    if (h0) begin
      xa = {me[31:12], ad[19:0]}; // R2
      to_link = me[`PIBT_MAP_LINK]; // R4
      endn = me[`PIBT_MAP_ENDIAN]; // R5
      l2ca = me[`PIBT_MAP_L2CA]; // R5
    end else if (h2 | h3) begin
      xa = (h2 ? `PIBT_MBOX0 : `PIBT_MBOX1) | {28'h0, ad[11:0]}; // R9
      mbox = 1'b1;
    end else if (hr) begin
      xa = `PIBT_ROMBASE | {24'h0, ad[15:0]}; // R12
    end else if (h4) begin
      xa = {11'h0, ad[28:0]}; // R10
      endn = ad[29]; // R10
    end else begin
      xa = {8'h0, 1'b1, ad[30], 1'b0, ad[28:0]}; // R11
      endn = ad[29]; // R11
    end
  end

  function [31:0] cfg_word;
    input [7:0] off;
    reg [5:0] mi;
    begin
      mi = off[7:2] - `PIBT_MAP0_IDX;
      cfg_word = 32'h0;
      case (off)
        `PIBT_OFF_MAPW: cfg_word = map_base | `PIBT_PREF; // R7
        `PIBT_OFF_MB0W: cfg_word = mb0_base | `PIBT_PREF; // R7
        `PIBT_OFF_MB1W: cfg_word = mb1_base | `PIBT_PREF; // R7
        `PIBT_OFF_LOWW: cfg_word = host_mode ? (low_base | `PIBT_PREF) : 32'h0;
        `PIBT_OFF_HIGHW:
          cfg_word = host_mode ? (high_base | `PIBT_PREF) : 32'h0;
        `PIBT_OFF_ROM: cfg_word = rom;
        `PIBT_OFF_EN: cfg_word = {30'h0, en_reg};
        default: begin
          if ((off >= `PIBT_OFF_MAP0) && (off <= `PIBT_OFF_MAPN))
            cfg_word = map_tab[mi[3:0]];
        end
      endcase
    end
  endfunction

  // Configuration space; the reserved slot at h14 always reads zero.
  always @(posedge clock or negedge rst_n) begin // R1
    if (!rst_n) begin
      map_base <= `PIBT_RST_MAPW; // R8
      mb0_base <= `PIBT_RST_MB0W;
      mb1_base <= `PIBT_RST_MB1W;
      low_base <= `PIBT_RST_LOWW;
      high_base <= `PIBT_RST_HIGHW;
      rom <= `PIBT_RST_ROM;
      en_reg <= `PIBT_RST_EN; // R10 R11
      for (i = 0; i < 16; i = i + 1)
        map_tab[i] <= 32'h0;
      host_mode <= 1'b0;
      strap_done <= 1'b0;
      sys_cfg_rdata <= 32'h0;
    end else begin
      strap_done <= 1'b1;
      if (!strap_done)
        host_mode <= host_strap;
      sys_cfg_rdata <= cfg_word(sys_cfg_addr);
      if (sys_cfg_wr && sys_cfg_addr == `PIBT_OFF_EN)
        en_reg <= sys_cfg_wdata[1:0];
      if (sys_cfg_wr && sys_map)
        map_tab[smi[3:0]] <= sys_cfg_wdata; // R6
      // PCI may move only device-mode bases; byte enables are not honoured.
      if (pwe && !host_mode) begin // R8
        case (cfg_off)
          `PIBT_OFF_MAPW: map_base <= ad & `PIBT_MSK_MAPW;
          `PIBT_OFF_MB0W: mb0_base <= ad & `PIBT_MSK_MBOX;
          `PIBT_OFF_MB1W: mb1_base <= ad & `PIBT_MSK_MBOX;
          `PIBT_OFF_ROM: rom <= ad & (`PIBT_MSK_ROM | `PIBT_ROM_EN);
          default: map_base <= map_base;
        endcase
      end
    end
  end

  // Transactions are served one at a time; a new frame arriving while an
  // internal request is outstanding is not claimed and sees a master abort.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      widx <= 3'h0;
      wr_q <= 1'b0;
      cfg_q <= 1'b0;
      mem_q <= 1'b0;
      mbox_q <= 1'b0;
      rdx_q <= 1'b0;
      cfg_off <= 8'h0;
      line_data <= 256'h0;
      line_be <= 32'h0;
      pci_ad_out <= 32'h0;
      pci_ad_oe_n <= 1'b1;
      target_claim_n <= 1'b1;
      pci_trdy_n <= 1'b1;
      pci_stop_n <= 1'b1;
      pci_ctl_oe_n <= 1'b1;
      ib_req <= 1'b0;
      ib_cmd <= 3'h0;
      ib_addr <= 40'h0;
      ib_be <= 32'h0;
      ib_to_link <= 1'b0;
      ib_endian <= 1'b0;
      l2_allocate_on_miss_flag <= 1'b0;
      snoop_owner <= 1'b0;
    end else begin
      ib_req <= 1'b0;
      snoop_owner <= (state == S_MERGE) & snoop_valid &
                     (snoop_line == ib_addr[39:5]); // R17
      case (state)
        S_IDLE: begin
          if (pedge & fr) begin
            widx <= ad[4:2];
            wr_q <= cmd[0];
            cfg_q <= is_cfg;
            cfg_off <= ad[7:0];
            mem_q <= xa_mem;
            mbox_q <= mbox;
            rdx_q <= 1'b0;
            line_be <= 32'h0;
            ib_addr <= {xa[39:5], 5'h00};
            ib_to_link <= to_link;
            ib_endian <= endn;
            l2_allocate_on_miss_flag <= l2ca & ~to_link;
            state <= S_DONE;
            if (is_cfg | hit) begin
              pci_ctl_oe_n <= 1'b0;
              target_claim_n <= 1'b0; // R3
              if (perr | (~is_cfg & abort_a)) begin
                pci_stop_n <= 1'b0; // R18
                state <= S_ABORT;
              end else if (cmd[0]) begin
                pci_trdy_n <= 1'b0;
                state <= S_WGATH;
              end else if (is_cfg) begin
                pci_ad_out <= cfg_word(ad[7:0]);
                pci_ad_oe_n <= 1'b0;
                pci_trdy_n <= 1'b0;
                state <= S_RDATA;
              end else begin
                state <= S_ISSUE;
              end
            end
          end
        end
        S_WGATH: begin
          if (pedge & ir) begin
            if (perr) begin
              pci_trdy_n <= 1'b1;
              pci_stop_n <= 1'b0; // R18
              state <= S_ABORT;
            end else if (cfg_q) begin
              pci_trdy_n <= 1'b1;
              state <= S_DONE;
            end else begin
              line_data[{widx, 5'h00} +: 32] <= ad; // R15
              line_be[{widx, 2'b00} +: 4] <= ~cmd; // R16
              widx <= widx + 3'd1;
              if (~fr | (widx == 3'd7)) begin
                pci_trdy_n <= 1'b1;
                pci_stop_n <= ~fr;
                state <= S_ISSUE;
              end
            end
          end
        end
        S_ISSUE: begin
          ib_req <= 1'b1;
          ib_be <= wr_q ? line_be : `PIBT_ALL_BE; // R13 R16
          state <= S_WAIT;
          if (ib_to_link)
            ib_cmd <= wr_q ? `PIBT_IB_UWR : `PIBT_IB_URD;
          else if (mbox_q & wr_q)
            ib_cmd <= `PIBT_IB_MBOX; // R9
          else if (wr_q & mem_q & (&line_be))
            ib_cmd <= `PIBT_IB_WINV; // R15
          else if (wr_q & mem_q) begin
            ib_cmd <= `PIBT_IB_RDX; // R15
            ib_be <= `PIBT_ALL_BE;
            rdx_q <= 1'b1;
          end else if (wr_q)
            ib_cmd <= `PIBT_IB_UWR; // R16
          else
            ib_cmd <= mem_q ? `PIBT_IB_CRD : `PIBT_IB_URD; // R13
        end
        S_WAIT: begin
          if (ib_done) begin
            if (rdx_q) begin
              line_data <= merged;
              line_be <= `PIBT_ALL_BE;
              ib_cmd <= `PIBT_IB_WB;
              ib_req <= 1'b1;
              state <= S_MERGE;
            end else if (wr_q) begin
              state <= S_DONE;
            end else if (ib_err) begin
              pci_stop_n <= 1'b0; // R19
              state <= S_ABORT;
            end else begin
              line_data <= ib_rdata;
              pci_ad_out <= ib_rdata[{widx, 5'h00} +: 32];
              pci_ad_oe_n <= 1'b0;
              pci_trdy_n <= 1'b0;
              state <= S_RDATA;
            end
          end
        end
        S_MERGE: begin
          if (ib_done)
            state <= S_DONE;
        end
        S_RDATA: begin
          if (pedge & ir) begin
            widx <= widx + 3'd1;
            pci_ad_out <= line_data[{widx + 3'd1, 5'h00} +: 32];
            if (~fr | cfg_q | (widx == 3'd7)) begin
              pci_trdy_n <= 1'b1;
              pci_ad_oe_n <= 1'b1;
              target_claim_n <= ~fr;
              pci_stop_n <= ~fr;
              state <= S_DONE;
            end
          end
        end
        S_ABORT: begin
          if (pedge) begin
            target_claim_n <= 1'b1; // R18
            pci_trdy_n <= 1'b1;
            pci_ad_oe_n <= 1'b1;
            if (~fr)
              state <= S_DONE;
          end
        end
        S_DONE: begin
          if (pedge & ~fr) begin
            target_claim_n <= 1'b1;
            pci_stop_n <= 1'b1;
            pci_trdy_n <= 1'b1;
            pci_ad_oe_n <= 1'b1;
            pci_ctl_oe_n <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/pibt_pci_master.sv ====
// Behavioural PCI bus master that runs single data phase transactions.
`default_nettype none
module pibt_pci_master (
  output logic pci_clk,
  output logic pci_frame_n,
  output logic pci_irdy_n,
  output logic pci_idsel,
  output logic pci_par,
  output logic [3:0] pci_cbe_n,
  output logic [31:0] m_ad,
  input wire logic claim_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic ctl_oe_n,
  input wire logic [31:0] ad
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pci_clk = 0;
    pci_frame_n = 1;
    pci_irdy_n = 1;
    pci_idsel = 0;
    pci_par = 0;
    pci_cbe_n = 4'hf;
    m_ad = 32'h0;
  end
  // The clock only runs inside a transaction, so the target must not
  // rely on a free-running clock to leave its busy state.
  task automatic cyc();
    #80 pci_clk = 1;
    #80 pci_clk = 0;
  endtask
  // Result 0 completed, 1 never claimed, 2 target abort.
  task automatic xfer(input logic [3:0] c, input logic [31:0] a,
      input logic [31:0] wd, input logic [3:0] be, input logic bp,
      output logic [31:0] rd, output logic [1:0] r);
    int n;
    r = 1;
    n = 0;
    pci_frame_n = 0;
    pci_idsel = c[3:1] == 3'b101;
    pci_cbe_n = c;
    m_ad = a;
    pci_par = ^{a, c} ^ bp;
    cyc();
    pci_frame_n = 1;
    pci_irdy_n = 0;
    pci_idsel = 0;
    pci_cbe_n = ~be;
    m_ad = c[0] ? wd : ~m_ad;
    pci_par = ^{m_ad, pci_cbe_n};
    while (r == 1 && n < 40 && !(n > 4 && (ctl_oe_n | claim_n))) begin
      #80 pci_clk = 1;
      n++;
      if (!(ctl_oe_n | stop_n)) r = 2;
      else if (!(ctl_oe_n | trdy_n)) r = 0;
      rd = ad;
      #80 pci_clk = 0;
    end
    pci_irdy_n = 1;
    m_ad = ~m_ad;
    pci_cbe_n = ~pci_cbe_n;
    repeat (3) cyc();
  endtask
endmodule
`default_nettype wire

// ==== tb/pibt_bridge_checker.sv ====
// Assertion checker on the ports of the inbound translation bridge.
`include "pibt_consts.vh"
`default_nettype none
module pibt_bridge_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ptp_en,
  input wire logic target_claim_n,
  input wire logic pci_trdy_n,
  input wire logic pci_stop_n,
  input wire logic pci_ctl_oe_n,
  input wire logic pci_ad_oe_n,
  input wire logic ib_req,
  input wire logic [2:0] ib_cmd,
  input wire logic [39:0] ib_addr,
  input wire logic [31:0] ib_be,
  input wire logic ib_to_link,
  input wire logic l2_allocate_on_miss_flag,
  input wire logic ib_done,
  input wire logic snoop_valid,
  input wire logic snoop_owner
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_abort_claimed;
    $fell(pci_stop_n) |-> !target_claim_n && !pci_ctl_oe_n;
  endproperty
  a_abort_claimed: assert property (p_abort_claimed)
    else $error("stop without claim");
  property p_ready_claimed;
    $fell(pci_trdy_n) |-> !target_claim_n && !pci_ctl_oe_n;
  endproperty
  a_ready_claimed: assert property (p_ready_claimed)
    else $error("ready without claim");
  property p_drive_claimed;
    !pci_ad_oe_n |-> !target_claim_n;
  endproperty
  a_drive_claimed: assert property (p_drive_claimed)
    else $error("data driven without claim");
  property p_full_line;
    ib_req && ib_cmd inside {`PIBT_IB_CRD, `PIBT_IB_URD, `PIBT_IB_RDX,
      `PIBT_IB_WINV} |-> ib_be == `PIBT_ALL_BE && ib_addr[4:0] == 5'h0;
  endproperty
  a_full_line: assert property (p_full_line)
    else $error("line request without all enables");
  property p_link_gated;
    ib_req && ib_to_link |-> ptp_en;
  endproperty
  a_link_gated: assert property (p_link_gated)
    else $error("link request while peer disabled");
  property p_link_no_alloc;
    ib_req && ib_to_link |-> !l2_allocate_on_miss_flag;
  endproperty
  a_link_no_alloc: assert property (p_link_no_alloc)
    else $error("allocate flag on link request");
  property p_internal_not_io;
    ib_req && !ib_to_link |-> !ib_addr[39] && ib_addr[39:29] != 11'h002;
  endproperty
  a_internal_not_io: assert property (p_internal_not_io)
    else $error("internal request into bridge space");
  property p_single_pulse;
    ib_req |=> !ib_req;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("request longer than one cycle");
  property p_wb_after_done;
    ib_req && ib_cmd == `PIBT_IB_WB |-> $past(ib_done);
  endproperty
  a_wb_after_done: assert property (p_wb_after_done)
    else $error("write back not after exclusive read");
  property p_owner_answers;
    snoop_owner |-> $past(snoop_valid);
  endproperty
  a_owner_answers: assert property (p_owner_answers)
    else $error("owner reply without snoop");
endmodule
bind pibt_bridge pibt_bridge_checker chk (.clock(clock), .rst_n(rst_n),
  .ptp_en(ptp_en), .target_claim_n(target_claim_n),
  .pci_trdy_n(pci_trdy_n), .pci_stop_n(pci_stop_n),
  .pci_ctl_oe_n(pci_ctl_oe_n), .pci_ad_oe_n(pci_ad_oe_n), .ib_req(ib_req),
  .ib_cmd(ib_cmd), .ib_addr(ib_addr), .ib_be(ib_be),
  .ib_to_link(ib_to_link), .ib_done(ib_done),
  .l2_allocate_on_miss_flag(l2_allocate_on_miss_flag),
  .snoop_valid(snoop_valid), .snoop_owner(snoop_owner));
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the inbound translation bridge.
`include "pibt_consts.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, host_strap, ptp_en, ib_done, ib_err, snoop_valid;
  logic pci_clk, frame_n, irdy_n, idsel, par, ad_oe_n, claim_n, trdy_n;
  logic stop_n, ctl_oe_n, ib_req, link, endian, l2, own, host_mode, wr;
  logic err_mode;
  logic [3:0] cbe_n;
  logic [31:0] m_ad, ad_out, ib_be, wdata, rdata, rd;
  logic [2:0] ib_cmd;
  logic [39:0] ib_addr;
  logic [255:0] ib_wdata, ib_rdata, snoop_data;
  logic [34:0] snoop_line;
  logic [7:0] addr;
  wire [31:0] ad = ad_oe_n ? m_ad : ad_out;
  int wt, n_own, n_checks, n_fail;
  logic [2:0] qc[$];
  logic [39:0] qa[$];
  logic [31:0] qb[$];
  logic [2:0] qf[$];
  logic [7:0] offs[9] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30,
    8'h40, 8'h44};
  logic [31:0] rv[9] = '{`PIBT_RST_MAPW | 4, 0, `PIBT_RST_MB0W | 4,
    `PIBT_RST_MB1W | 4, `PIBT_RST_LOWW | 4, `PIBT_RST_HIGHW | 4,
    `PIBT_RST_ROM, 3, 0};
  logic [31:0] ta[6] = '{32'h70000040, 32'h71000080, 32'h20000100,
    32'h00001000, 32'hb0000040, 32'hc0000000};
  pibt_bridge dut (.clock(clock), .rst_n(rst_n), .host_strap(host_strap),
    .ptp_en(ptp_en), .pci_clk(pci_clk), .pci_frame_n(frame_n),
    .pci_irdy_n(irdy_n), .pci_idsel(idsel), .pci_par(par),
    .pci_cbe_n(cbe_n), .pci_ad_in(ad), .pci_ad_out(ad_out),
    .pci_ad_oe_n(ad_oe_n), .target_claim_n(claim_n), .pci_trdy_n(trdy_n),
    .pci_stop_n(stop_n), .pci_ctl_oe_n(ctl_oe_n), .ib_req(ib_req),
    .ib_cmd(ib_cmd), .ib_addr(ib_addr), .ib_be(ib_be), .ib_wdata(ib_wdata),
    .ib_to_link(link), .ib_endian(endian), .l2_allocate_on_miss_flag(l2),
    .ib_done(ib_done), .ib_err(ib_err), .ib_rdata(ib_rdata),
    .snoop_valid(snoop_valid), .snoop_line(snoop_line), .snoop_owner(own),
    .snoop_data(snoop_data), .sys_cfg_wr(wr), .sys_cfg_addr(addr),
    .sys_cfg_wdata(wdata), .sys_cfg_rdata(rdata), .host_mode(host_mode));
  pibt_pci_master m (.pci_clk(pci_clk), .pci_frame_n(frame_n),
    .pci_irdy_n(irdy_n), .pci_idsel(idsel), .pci_par(par),
    .pci_cbe_n(cbe_n), .m_ad(m_ad), .claim_n(claim_n), .trdy_n(trdy_n),
    .stop_n(stop_n), .ctl_oe_n(ctl_oe_n), .ad(ad));
  // Internal bus responder; it snoops each write back while it is pending.
  always @(posedge clock) begin
    ib_done <= 0;
    snoop_valid <= 0;
    if (own) n_own <= n_own + 1;
    if (ib_req) begin
      qc.push_back(ib_cmd);
      qa.push_back(ib_addr);
      qb.push_back(ib_be);
      qf.push_back({link, endian, l2});
      wt <= 2 + $urandom % 5;
      if (ib_cmd != `PIBT_IB_WB && ib_cmd != `PIBT_IB_UWR)
        ib_rdata <= {ib_rdata[223:0], $urandom};
      snoop_valid <= ib_cmd == `PIBT_IB_WB;
      snoop_line <= ib_addr[39:5];
    end else if (wt > 0) begin
      wt <= wt - 1;
      ib_done <= wt == 1;
      ib_err <= err_mode;
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic sysw(logic [7:0] a, logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    step(1);
    wr = 0;
  endtask
  task automatic cfg(logic [7:0] a, logic [31:0] e);
    addr = a;
    step(2);
    `CHK("config word", e, rdata)
  endtask
  task automatic pci(logic [3:0] c, logic [31:0] a, logic [31:0] wd,
      logic [3:0] be, logic bp, logic [1:0] e);
    logic [1:0] r;
    step(1);
    qc.delete();
    qa.delete();
    qb.delete();
    qf.delete();
    m.xfer(c, a, wd, be, bp, rd, r);
    `CHK("outcome", e, r)
  endtask
  function automatic logic [1:0] mexp(logic [31:0] t, logic [39:0] x,
      logic p, logic er);
    if (!t[0]) return 1;
    if (t[1] ? !p : (x[39] || x[39:29] == 11'h002)) return 2;
    return er ? 2 : 0;
  endfunction
  function automatic logic [2:0] rdcmd(logic [39:0] x);
    return !x[39] && (x[39:32] != 0 || x[31:28] == 0 || x[31]) ?
      `PIBT_IB_CRD : `PIBT_IB_URD;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  initial begin
    #500us;
    n_fail++;
    end_sim;
  end
  initial begin : main
    logic [31:0] t, a;
    logic [39:0] xa;
    int i, k, o;
    {rst_n, ptp_en, ib_err, snoop_line, ib_rdata, wr, addr, wdata} = 0;
    {ib_done, snoop_valid, err_mode} = 0;
    host_strap = 1;
    void'($urandom(32'h532749b5));
    step(3);
    rst_n = 1;
    step(4);
    `CHK("mode", 1'b1, host_mode)
    foreach (offs[j]) cfg(offs[j], rv[j]);
    pci(`PIBT_CWR, 32'h10, 32'h12000000, 4'hf, 0, 0);
    pci(`PIBT_CWR, 32'h44, 32'h00000001, 4'hf, 0, 0);
    cfg(8'h10, rv[0]);
    pci(`PIBT_CRD, 32'h10, 0, 4'hf, 0, 0);
    `CHK("cfg read", rv[0], rd)
    cfg(8'h44, 0);
    $display("test reset done");
    for (k = 0; k < 24; k++) begin
      i = $urandom % 16;
      t = $urandom & 32'hfffff00f;
      if (k % 2) t[31:24] = 0;
      ptp_en = $urandom;
      err_mode = $urandom % 4 == 0;
      sysw(8'h44 + 8'(4 * i), t);
      cfg(8'h44 + 8'(4 * i), t);
      a = 32'h60000000 | (i << 20) | ($urandom & 32'hfffc0);
      xa = {t[31:12], a[19:0]};
      pci(`PIBT_MRD, a, 0, 4'hf, 0, mexp(t, xa, ptp_en, err_mode));
      if (mexp(t, xa, ptp_en, err_mode) == 0) begin
        `CHK("addr", {xa[39:5], 5'h0}, qa[0])
        `CHK("link", t[1], qf[0][2])
        `CHK("alloc", t[3] & ~t[1], qf[0][0])
        `CHK("data", ib_rdata[31:0], rd)
        if (!t[1]) `CHK("cmd", rdcmd(xa), qc[0])
        if (!t[1]) `CHK("endian", t[2], qf[0][1])
      end
    end
    $display("test map done");
    {ptp_en, err_mode} = 2'b10;
    sysw(8'h4c, 32'h01000001);
    o = n_own;
    pci(`PIBT_MWR, 32'h60200008, 32'hcafe1234, 4'h3, 0, 0);
    `CHK("excl", `PIBT_IB_RDX, qc[0])
    `CHK("wb", `PIBT_IB_WB, qc[1])
    `CHK("owner", o + 1, n_own)
    `CHK("merge", {ib_rdata[95:80], 16'h1234}, snoop_data[95:64])
    `CHK("wdata", {ib_rdata[95:80], 16'h1234}, ib_wdata[95:64])
    sysw(8'h50, 32'h00100001);
    pci(`PIBT_MWR, 32'h60300014, 32'h55aa55aa, 4'h5, 0, 0);
    `CHK("uwr", `PIBT_IB_UWR, qc[0])
    `CHK("be", 32'h5 << 20, qb[0])
    $display("test write done");
    foreach (ta[j]) begin
      a = ta[j];
      xa = a[31:28] == 4'h7 ? `PIBT_MBOX0 + {a[24], 13'h0} + a[11:0] :
        {8'h0, a & 32'hdfffffff};
      pci(`PIBT_MRD, a, 0, 4'hf, 0, 0);
      `CHK("addr", {xa[39:5], 5'h0}, qa[0])
      `CHK("cmd", rdcmd(xa), qc[0])
      if (a[31:28] != 4'h7) `CHK("endian", a[29], qf[0][1])
    end
    pci(`PIBT_MWR, 32'h71000008, 32'h1, 4'hf, 0, 0);
    `CHK("mbox", `PIBT_IB_MBOX, qc[0])
    sysw(`PIBT_OFF_EN, 32'h2);
    pci(`PIBT_MRD, 32'h00000100, 0, 4'hf, 0, 1);
    pci(`PIBT_MRD, 32'h80000000, 0, 4'hf, 0, 0);
    sysw(`PIBT_OFF_EN, 32'h0);
    pci(`PIBT_MRD, 32'h80000000, 0, 4'hf, 0, 1);
    sysw(`PIBT_OFF_EN, 32'h3);
    pci(`PIBT_MRD, 32'h00000200, 0, 4'hf, 1, 2);
    pci(4'h2, 32'h00000200, 0, 4'hf, 0, 2);
    $display("test window done");
    host_strap = 0;
    rst_n = 0;
    step(3);
    rst_n = 1;
    step(4);
    `CHK("mode", 1'b0, host_mode)
    cfg(8'h20, 0);
    pci(`PIBT_CWR, 32'h44, 32'h00000001, 4'hf, 0, 0);
    cfg(8'h44, 0);
    pci(`PIBT_CWR, 32'h30, 32'h50000001, 4'hf, 0, 0);
    pci(`PIBT_MRD, 32'h50000100, 0, 4'hf, 0, 0);
    `CHK("rom", `PIBT_ROMBASE + 40'h100, qa[0])
    pci(`PIBT_CWR, 32'h30, 32'h50000000, 4'hf, 0, 0);
    pci(`PIBT_MRD, 32'h50000100, 0, 4'hf, 0, 1);
    pci(`PIBT_CWR, 32'h18, 32'h30000000, 4'hf, 0, 0);
    pci(`PIBT_MRD, 32'h30000000, 0, 4'hf, 0, 0);
    `CHK("mbox", `PIBT_MBOX0, qa[0])
    $display("test device done");
    end_sim;
  end
endmodule
`default_nettype wire
